// ### pkg/ppod_map.svh
/*
 pad pull and open-drain configuration: register offsets, pull codes, reset values.
 assumes inclusion by bare name from the core.
*/
`ifndef PPOD_MAP_SVH
`define PPOD_MAP_SVH
`define PPOD_ADDR_ROW_HIGH_PULL 8'hae
`define PPOD_ADDR_COL_OD_EN 8'he0
`define PPOD_ADDR_COL_OD_SRC 8'he1
`define PPOD_ADDR_ROW_LOW_OD_EN 8'he2
`define PPOD_ADDR_ROW_LOW_OD_SRC 8'he3
`define PPOD_ADDR_ROW_HIGH_OD_EN 8'he4
`define PPOD_ADDR_ROW_HIGH_OD_SRC 8'he5
`define PPOD_PULL_RESV_VALUE 8'h5a
`define PPOD_PULL_RESET 8'h15
`define PPOD_ROW_HIGH_OD_EN_RESET 4'h8
`define PPOD_ROW_HIGH_OD_SRC_RESET 4'h0
`define PPOD_BYTE_RESET 8'h00
`define PPOD_PULL_NONE 2'h0
`define PPOD_PULL_DOWN 2'h1
`define PPOD_PULL_UP_READ 2'h3
`endif

// ### pkg/ppod_pkg.sv
/*
 types for the pad configuration block.
 assumes ppod_map.svh is on the include path.
*/
package ppod_pkg;
   // register write strobe with address and 16-bit data
   typedef struct packed {
      logic wr;
      logic [7:0] addr;
      logic [15:0] data;
   } ppod_wr_s;
   // resolved pad pull controls for one pin group
   typedef struct packed {
      logic [11:0] pull_up;
      logic [11:0] pull_down;
   } ppod_pull_s;
   // pull resistor choice for one pin
   typedef enum logic [1:0] {
      PPOD_NO_PULL,
      PPOD_PULLDOWN,
      PPOD_PULLUP
   } ppod_pull_e;
endpackage : ppod_pkg

// ### core/ppod_cfg.sv
/*
 pad pull and output-driver style configuration registers with resolved pad controls.
 assumes a serial slave front end delivers decoded one-cycle register writes and reads.
*/
// Behaviour
// RULE1: pull code 00 none, 01 pulldown, upper bit set pullup.
// RULE2: writing 2 or 3 into a pull field reads back as 3.
// RULE3: high-row pull register: row11 bits 7:6, 10 5:4, 9 3:2, 8 1:0.
// RULE4: pull reset: row11 none, rows 10..8 pulldown; bits 15:8 read 0x5A.
// RULE5: column open-drain enable bit 0 full buffer, 1 open drain.
// RULE6: in open drain, source 0 n-channel only, 1 p-channel only.
// RULE7: source select matters only when open-drain enable set.
// RULE8: rows 7..0 have own enable and source registers, bit n pin n.
// RULE9: row 11..8 enable in bits 3:0; bits 7:4 read zero.
// RULE10: row 11..8 enable resets to 0x8, interrupt pad open drain.
// RULE11: column and row 7..0 enable and source registers reset to zero.
// RULE12: row 11..8 source select in bits 3:0 of separate register.
// RULE13: reserved writes ignored; outputs change the cycle after a write. Here pad and pull outputs change two cycles after the write.
`timescale 1ns/10ps
`include "ppod_map.svh"
module ppod_cfg
   import ppod_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // register access
   input wire ppod_wr_s reg_wr,
   input wire logic [7:0] rd_addr,
   output logic [15:0] rd_data,
   // pull controls for row pins 11..8
   output logic [3:0] row_high_pull_up,
   output logic [3:0] row_high_pull_down,
   // driver stage enables, column pins 7..0 then row pins 11..0
   output logic [19:0] pad_nmos_en,
   output logic [19:0] pad_pmos_en
);
   logic [7:0] row_high_pull_config;
   logic [7:0] column_od_enable;
   logic [7:0] column_od_source;
   logic [7:0] row_low_od_enable;
   logic [7:0] row_low_od_source;
   logic [3:0] row_high_od_enable;
   logic [3:0] row_high_od_source;
   logic [19:0] next_nmos;
   logic [19:0] next_pmos;
   logic [19:0] od_en_all;
   logic [19:0] od_src_all;
   logic [15:0] next_rd;

   // fold a written pull byte: upper bit set stores 3
   function automatic logic [7:0] fold_pull(input logic [7:0] v);
      logic [7:0] r;
      r = v;
      for (int i = 0; i < 4; i++) begin
         if (v[2*i+1]) begin
            r[2*i +: 2] = `PPOD_PULL_UP_READ; // see RULE2
         end
      end
      return r;
   endfunction : fold_pull

   // decode one pull field into its enum
   function automatic ppod_pull_e pull_kind(input logic [1:0] f);
      if (f[1]) begin
         return PPOD_PULLUP; // see RULE1
      end else if (f == `PPOD_PULL_DOWN) begin
         return PPOD_PULLDOWN;
      end else begin
         return PPOD_NO_PULL;
      end
   endfunction : pull_kind

   // pull register, reserved upper byte is fixed and not stored
   always_ff @(posedge clk) begin
      if (srst) begin
         row_high_pull_config <= `PPOD_PULL_RESET; // see RULE4
      end else if (reg_wr.wr && reg_wr.addr == `PPOD_ADDR_ROW_HIGH_PULL) begin
         row_high_pull_config <= fold_pull(reg_wr.data[7:0]); // see RULE3 see RULE13
      end
   end

   // column open-drain registers
   always_ff @(posedge clk) begin
      if (srst) begin
         column_od_enable <= `PPOD_BYTE_RESET; // see RULE11
         column_od_source <= `PPOD_BYTE_RESET;
      end else if (reg_wr.wr) begin
         if (reg_wr.addr == `PPOD_ADDR_COL_OD_EN) begin
            column_od_enable <= reg_wr.data[7:0]; // see RULE5
         end else if (reg_wr.addr == `PPOD_ADDR_COL_OD_SRC) begin
            column_od_source <= reg_wr.data[7:0];
         end
      end
   end

   // row 7..0 open-drain registers
   always_ff @(posedge clk) begin
      if (srst) begin
         row_low_od_enable <= `PPOD_BYTE_RESET; // see RULE11
         row_low_od_source <= `PPOD_BYTE_RESET;
      end else if (reg_wr.wr) begin
         if (reg_wr.addr == `PPOD_ADDR_ROW_LOW_OD_EN) begin
            row_low_od_enable <= reg_wr.data[7:0]; // see RULE8
         end else if (reg_wr.addr == `PPOD_ADDR_ROW_LOW_OD_SRC) begin
            row_low_od_source <= reg_wr.data[7:0];
         end
      end
   end

   // row 11..8 open-drain registers, upper nibble discarded
   always_ff @(posedge clk) begin
      if (srst) begin
         row_high_od_enable <= `PPOD_ROW_HIGH_OD_EN_RESET; // see RULE10
         row_high_od_source <= `PPOD_ROW_HIGH_OD_SRC_RESET; // see RULE12
      end else if (reg_wr.wr) begin
         if (reg_wr.addr == `PPOD_ADDR_ROW_HIGH_OD_EN) begin
            row_high_od_enable <= reg_wr.data[3:0]; // see RULE9 see RULE13
         end else if (reg_wr.addr == `PPOD_ADDR_ROW_HIGH_OD_SRC) begin
            row_high_od_source <= reg_wr.data[3:0]; // see RULE12
         end
      end
   end

   // gather per-pin controls, columns low then rows
   assign od_en_all = {row_high_od_enable, row_low_od_enable, column_od_enable};
   assign od_src_all = {row_high_od_source, row_low_od_source, column_od_source};

   // resolve driver transistors per pin
   always_comb begin
      for (int i = 0; i < 20; i++) begin
         if (od_en_all[i]) begin
            next_nmos[i] = ~od_src_all[i]; // see RULE6 see RULE7
            next_pmos[i] = od_src_all[i];
         end else begin
            next_nmos[i] = 1'b1; // see RULE5
            next_pmos[i] = 1'b1;
         end
      end
   end

   // registered pad controls
   always_ff @(posedge clk) begin
      if (srst) begin
         pad_nmos_en <= 20'hfffff;
         pad_pmos_en <= 20'hfffff;
         row_high_pull_up <= 4'h0;
         row_high_pull_down <= 4'h0;
      end else begin
         pad_nmos_en <= next_nmos;
         pad_pmos_en <= next_pmos;
         for (int i = 0; i < 4; i++) begin
            row_high_pull_up[i] <= pull_kind(row_high_pull_config[2*i +: 2]) == PPOD_PULLUP; // see RULE1
            row_high_pull_down[i] <= pull_kind(row_high_pull_config[2*i +: 2]) == PPOD_PULLDOWN;
         end
      end
   end

   // read decode, unmapped addresses read zero
   always_comb begin
      if (rd_addr == `PPOD_ADDR_ROW_HIGH_PULL) begin
         next_rd = {`PPOD_PULL_RESV_VALUE, row_high_pull_config}; // see RULE4
      end else if (rd_addr == `PPOD_ADDR_COL_OD_EN) begin
         next_rd = {8'h00, column_od_enable};
      end else if (rd_addr == `PPOD_ADDR_COL_OD_SRC) begin
         next_rd = {8'h00, column_od_source};
      end else if (rd_addr == `PPOD_ADDR_ROW_LOW_OD_EN) begin
         next_rd = {8'h00, row_low_od_enable};
      end else if (rd_addr == `PPOD_ADDR_ROW_LOW_OD_SRC) begin
         next_rd = {8'h00, row_low_od_source};
      end else if (rd_addr == `PPOD_ADDR_ROW_HIGH_OD_EN) begin
         next_rd = {12'h000, row_high_od_enable}; // see RULE9
      end else if (rd_addr == `PPOD_ADDR_ROW_HIGH_OD_SRC) begin
         next_rd = {12'h000, row_high_od_source};
      end else begin
         next_rd = 16'h0000;
      end
   end

   // registered read data
   always_ff @(posedge clk) begin
      if (srst) begin
         rd_data <= 16'h0000;
      end else begin
         rd_data <= next_rd;
      end
   end

   // pull write of 2 reads back as 3 after write
   a_pull_fold: assert property (@(posedge clk) disable iff (srst)
      reg_wr.wr && reg_wr.addr == `PPOD_ADDR_ROW_HIGH_PULL && reg_wr.data[7:6] == 2'h2
      |=> row_high_pull_config[7:6] == 2'h3) else $error("pull field not folded to 3"); // see RULE2

   // pullup output follows field one cycle later
   a_pull_up_out: assert property (@(posedge clk) disable iff (srst)
      row_high_pull_config[1] |=> row_high_pull_up[0] && !row_high_pull_down[0])
      else $error("row8 pullup not applied"); // see RULE1

   a_pull_down_out: assert property (@(posedge clk) disable iff (srst)
      row_high_pull_config[3:2] == 2'h1 |=> row_high_pull_down[1] && !row_high_pull_up[1])
      else $error("row9 pulldown not applied"); // see RULE3

   // read data is cleared by reset, so the edge just after release is skipped
   a_reserved_pull: assert property (@(posedge clk) disable iff (srst)
      !$past(srst) && $past(rd_addr) == `PPOD_ADDR_ROW_HIGH_PULL |-> rd_data[15:8] == 8'h5a)
      else $error("reserved pull byte wrong"); // see RULE4

   sequence s_col_od_write;
      reg_wr.wr && reg_wr.addr == `PPOD_ADDR_COL_OD_EN && reg_wr.data[0];
   endsequence
   a_col_od_mode: assert property (@(posedge clk) disable iff (srst)
      s_col_od_write ##1 (column_od_source[0] && !reg_wr.wr) |=> !pad_nmos_en[0] && pad_pmos_en[0])
      else $error("column open drain pmos source wrong"); // see RULE6

   a_full_buffer: assert property (@(posedge clk) disable iff (srst)
      !od_en_all[12] |=> pad_nmos_en[12] && pad_pmos_en[12])
      else $error("full buffer not used on row4"); // see RULE7

   a_row_high_resv: assert property (@(posedge clk) disable iff (srst)
      $past(rd_addr) == `PPOD_ADDR_ROW_HIGH_OD_EN |-> rd_data[15:4] == 12'h000)
      else $error("row high enable reserved bits nonzero"); // see RULE9

   a_reset_values: assert property (@(posedge clk)
      $past(srst) |-> row_high_od_enable == 4'h8 && column_od_enable == 8'h00 && row_high_pull_config == 8'h15)
      else $error("reset values wrong"); // see RULE10

   a_row_low_nmos: assert property (@(posedge clk) disable iff (srst)
      od_en_all[8] && !od_src_all[8] |=> pad_nmos_en[8] && !pad_pmos_en[8])
      else $error("row0 nmos only not applied"); // see RULE8
endmodule : ppod_cfg

// ### verification/ppod_host_model.sv
/*
 host side of the pad configuration block: one-cycle register writes and read addresses.
 assumes a free-running clk and no request before the block leaves reset.
*/
`timescale 1ns/10ps
module ppod_host_model
   import ppod_pkg::*;
(
   // clock
   input wire logic clk,
   // register access toward the block
   output ppod_wr_s reg_wr,
   output logic [7:0] rd_addr
);
   // idle bus from time zero
   initial begin
      reg_wr = '0;
      rd_addr = 8'h00;
   end
   // write strobe for one cycle, optionally after some idle cycles
   task automatic wr(input logic [7:0] a, input logic [15:0] d, input int gap);
      repeat (gap) @(posedge clk);
      @(posedge clk);
      #1;
      reg_wr = '{wr: 1'b1, addr: a, data: d};
      @(posedge clk);
      #1;
      reg_wr.wr = 1'b0;
   endtask : wr
   // read address held until the following edge has captured it
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      #1;
      rd_addr = a;
      @(posedge clk);
      #1;
   endtask : rd
endmodule : ppod_host_model

// ### verification/pad_pull_open_drain_cfg_tb.sv
/*
 self-checking bench for the pad configuration block, with a shadow of every register.
 assumes ppod_host_model drives the register side and ppod_map.svh is on the include path.
*/
`timescale 1ns/10ps
module pad_pull_open_drain_cfg_tb import ppod_pkg::*;;
   logic clk;
   logic srst;
   ppod_wr_s reg_wr;
   logic [7:0] rd_addr;
   logic [15:0] rd_data;
   logic [3:0] pu;
   logic [3:0] pd;
   logic [19:0] nen;
   logic [19:0] pen;
   int miscompares = 0;
   int comparisons = 0;
   logic [31:0] seed = 32'hbba0b98b;
   logic [7:0] pull;
   logic [7:0] ce;
   logic [7:0] cs;
   logic [7:0] le;
   logic [7:0] ls;
   logic [3:0] he;
   logic [3:0] hs;
   logic [63:0] exp_q[$];
   logic kind_q[$];
   event got;
   logic [7:0] addrs[9] = '{8'hae, 8'he0, 8'he1, 8'he2, 8'he3, 8'he4, 8'he5, 8'had, 8'he6};
   // clock at 100 mhz
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   ppod_cfg DUT (.clk(clk), .srst(srst), .reg_wr(reg_wr), .rd_addr(rd_addr), .rd_data(rd_data),
      .row_high_pull_up(pu), .row_high_pull_down(pd), .pad_nmos_en(nen), .pad_pmos_en(pen));
   ppod_host_model host (.clk(clk), .reg_wr(reg_wr), .rd_addr(rd_addr));
   // random source
   function automatic logic [31:0] xorshift(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      x = x ^ (x << 5);
      return x;
   endfunction : xorshift
   // expected pad controls from the shadow registers
   function automatic logic [47:0] pads();
      logic [19:0] en;
      logic [19:0] src;
      logic [3:0] up;
      logic [3:0] dn;
      en = {he, le, ce};
      src = {hs, ls, cs};
      for (int i = 0; i < 4; i++) begin
         up[i] = pull[2*i+1];
         dn[i] = (pull[2*i +: 2] == 2'h1);
      end
      return {up, dn, ~en | ~src, ~en | src};
   endfunction : pads
   // expected read value of an address
   function automatic logic [15:0] regval(input logic [7:0] a);
      case (a)
         8'hae: return {8'h5a, pull};
         8'he0: return {8'h00, ce};
         8'he1: return {8'h00, cs};
         8'he2: return {8'h00, le};
         8'he3: return {8'h00, ls};
         8'he4: return {12'h000, he};
         8'he5: return {12'h000, hs};
         default: return 16'h0000;
      endcase
   endfunction : regval
   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] want);
      comparisons++;
      if (seen !== want) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, want, seen);
      end
   endtask : check
   // note the expected pads once the write has reached the outputs
   task automatic expect_pads();
      @(posedge clk);
      #1;
      exp_q.push_back({16'h0000, pads()});
      kind_q.push_back(1'b1);
      -> got;
   endtask : expect_pads
   task automatic put(input logic [7:0] a, input logic [15:0] d, input int gap);
      host.wr(a, d, gap);
      case (a)
         8'hae: for (int i = 0; i < 4; i++) pull[2*i +: 2] = d[2*i+1] ? 2'h3 : d[2*i +: 2];
         8'he0: ce = d[7:0];
         8'he1: cs = d[7:0];
         8'he2: le = d[7:0];
         8'he3: ls = d[7:0];
         8'he4: he = d[3:0];
         8'he5: hs = d[3:0];
         default: ;
      endcase
      expect_pads();
   endtask : put
   task automatic look(input logic [7:0] a);
      host.rd(a);
      exp_q.push_back({48'h0, regval(a)});
      kind_q.push_back(1'b0);
      -> got;
   endtask : look
   task automatic check_all();
      foreach (addrs[i]) look(addrs[i]);
      expect_pads();
   endtask : check_all
   // reset held three cycles, shadow back to defaults
   task automatic do_reset();
      srst = 1'b1;
      repeat (3) @(posedge clk);
      #1;
      srst = 1'b0;
      pull = 8'h15;
      {ce, cs, le, ls} = 32'h0;
      he = 4'h8;
      hs = 4'h0;
   endtask : do_reset
   // compare each result against the oldest note
   always @(got) begin
      if (kind_q.pop_front())
         check("pads", {16'h0000, pu, pd, nen, pen}, exp_q.pop_front());
      else
         check("rd_data", {48'h0, rd_data}, exp_q.pop_front());
   end
   task automatic final_report();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : final_report
   // watchdog well beyond the expected run
   initial begin
      #50000;
      miscompares++;
      final_report();
   end
   initial begin
      do_reset();
      check_all();
      $display("test reset values done");
      // every pull code in all fields, reserved byte written with ones
      for (int c = 0; c < 4; c++) begin
         put(8'hae, {8'hff, {4{c[1:0]}}}, 0);
         look(8'hae);
      end
      $display("test pull codes done");
      // column 0 open drain on the p-channel, row 0 open drain on the n-channel
      put(8'he1, 16'hff01, 0);
      put(8'he0, 16'hff01, 0);
      put(8'he3, 16'hff00, 0);
      put(8'he2, 16'hff01, 1);
      put(8'he5, 16'hfff1, 0);
      look(8'he5);
      $display("test open drain sources done");
      // random data to mapped and unmapped places, prompt and slow
      repeat (60) begin
         seed = xorshift(seed);
         put(addrs[seed[19:16] % 9], seed[15:0], int'(seed[30:29]));
         look(addrs[seed[27:24] % 9]);
      end
      check_all();
      $display("test random writes done");
      do_reset();
      check_all();
      $display("test second reset done");
      final_report();
   end
endmodule : pad_pull_open_drain_cfg_tb
